// ===== dv/nine_track_backward_read_and_erase_bench.sv
`timescale 1ns/1ps
module nine_track_backward_read_and_erase_bench;
	reg          clk = 1'b0, rst_n = 1'b0, go = 1'b0, even = 1'b0, stall = 1'b0, sel = 1'b0;
	reg          fv = 1'b0, bend = 1'b0, spd = 1'b0, wrdy = 1'b0, st_ab, st_irq, mseen = 1'b0;
	reg  [2:0]   code = 3'h0;
	reg  [3:0]   nw = 4'h0;
	reg  [4:0]   sp = 5'h00;
	reg  [7:0]   fr = 8'h00, fb, frames [0:31];
	reg  [29:0]  words [0:15];
	reg  [149:0] acc;
	reg  [119:0] wbits;
	wire         fval, feven, dval, dlast, drdy, wordv, wordr, busy, frdy, wrv, mf, er, stv, ab, irq;
	wire [2:0]   fcode;
	wire [29:0]  dword, wdata;
	wire [7:0]   wrf;
	wire         mr;
	integer      n_mismatch = 0, checks_done = 0, cyc = 0, i, j, k, nf, st_n = 0, nfr = 0, nwd = 0;
	always #50 clk = ~clk;
	processor_channel_model cpu_u (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_code(code),
		.i_even(even), .i_nwords(nw), .i_stall(stall), .i_data_ready(drdy), .o_func_valid(fval),
		.o_func_code(fcode), .o_func_even_parity(feven), .o_data_valid(dval),
		.o_data_word(dword), .o_data_last(dlast), .o_word_ready(wordr));
	nine_track_backward_read_and_erase #(.ERASE_CYCLES(8)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
		.i_ce(1'b1), .i_func_valid(fval), .i_func_code(fcode), .i_func_even_parity(feven),
		.i_track_count_selector(sel), .o_busy(busy), .i_data_valid(dval), .i_data_word(dword),
		.i_data_last(dlast), .o_data_ready(drdy), .o_word_valid(wordv), .o_word_data(wdata),
		.i_word_ready(wordr), .i_rd_frame_valid(fv), .i_rd_frame(fr), .i_rd_block_end(bend),
		.o_rd_frame_ready(frdy), .o_wr_frame_valid(wrv), .o_wr_frame(wrf),
		.i_wr_frame_ready(wrdy), .i_at_speed(spd), .o_motion_fwd(mf), .o_motion_rev(mr),
		.o_erase_on(er), .o_status_valid(stv), .o_status_abnormal(ab), .o_ext_interrupt(irq));
	// capture delivered words, written frames and status pulses
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (wordv && wordr) begin
			words[nwd] = wdata;
			nwd = nwd + 1;
		end
		if (wrv && wrdy) begin
			frames[nfr] = wrf;
			nfr = nfr + 1;
		end
		if (stv) begin
			st_n = st_n + 1;
			st_ab = ab;
			st_irq = irq;
		end
		if (mf)
			mseen = 1'b1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			complete_run;
		end
	end
	// tape reaches speed a few cycles into motion; the writer stalls one cycle in three
	always @(negedge clk) begin
		sp <= {sp[3:0], mf};
		spd <= &sp;
		wrdy <= (cyc % 3) != 0;
	end
	task check(input [29:0] seen, input [29:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("Error %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task run(input [2:0] c, input e, input [3:0] n);
		begin
			// non-blocking so the model sees go one full cycle, free of races
			@(negedge clk);
			{code, even, nw, go} <= {c, e, n, 1'b1};
			@(negedge clk);
			go <= 1'b0;
		end
	endtask
	task wait_status(input integer s0);
		begin
			for (k = 0; st_n == s0 && k < 300; k = k + 1)
				@(negedge clk);
			if (st_n == s0) begin
				n_mismatch = n_mismatch + 1;
				$display("Error %0t: no status pulse", $time);
			end
		end
	endtask
	task send_frame(input [7:0] f);
		begin
			@(negedge clk);
			fv = 1'b1;
			fr = f;
			for (k = 0; !frdy && k < 50; k = k + 1)
				@(negedge clk);
			if (!frdy) begin
				n_mismatch = n_mismatch + 1;
				$display("Error %0t: frame not taken", $time);
			end
			@(posedge clk);
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", checks_done, n_mismatch);
			if (n_mismatch == 0 && checks_done > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	initial begin
		#300 rst_n = 1'b1;
		// seven-track function is ignored
		run(3'h7, 1'b1, 4'h0);
		repeat (3) @(negedge clk);
		check(busy, 1'b0);
		sel = 1'b1;
		$display("test seven_track done");
		// erase only: no motion before the single word, then status and interrupt
		run(3'h7, 1'b1, 4'h0);
		repeat (6) @(negedge clk);
		check(mf, 1'b0);
		i = st_n;
		run(3'h7, 1'b1, 4'h1);
		wait_status(i);
		check(st_irq, 1'b1);
		check(mseen, 1'b1);
		check(nfr, 0);
		$display("test erase_only done");
		// odd parity skip then write of four words
		repeat (3) @(negedge clk);
		i = st_n;
		run(3'h7, 1'b0, 4'h4);
		wait_status(i);
		for (j = 0; j < 4; j = j + 1)
			wbits = {wbits[89:0], cpu_u.word_of(j[3:0])};
		check(nfr, 15);
		for (j = 0; j < 15; j = j + 1)
			check(frames[j], wbits[119 - 8 * j -: 8]);
		$display("test skip_write done");
		// backward reads of 16 and 15 frames, receiver stalling on the first
		for (nf = 16; nf >= 15; nf = nf - 1) begin
			repeat (3) @(negedge clk);
			{acc, nwd, stall, i} = {150'h0, 32'h0, nf == 16, st_n};
			run(3'h3, 1'b0, 4'h0);
			for (j = 1; j <= nf; j = j + 1) begin
				fb = j * 8'h1d + 8'h07;
				acc = acc | ({142'h0, fb} << (8 * j - 8));
				send_frame(fb);
				if (j == 8 && stall) begin
					@(negedge clk);
					fv = 1'b0;
					repeat (3) @(negedge clk);
					check(frdy, 1'b0);
					stall = 1'b0;
				end
			end
			@(negedge clk);
			{fv, fr, bend} = {1'b0, ~fr, 1'b1};
			check(mr, 1'b1);
			// block end stands until the device can take it
			for (k = 0; !frdy && k < 50; k = k + 1)
				@(negedge clk);
			@(negedge clk);
			bend = 1'b0;
			wait_status(i);
			repeat (4) @(negedge clk);
			check(mr, 1'b0);
			check(nwd, (nf * 8 + 29) / 30);
			for (j = 0; j < nwd; j = j + 1)
				check(words[j], acc[30 * j +: 30]);
			check(st_ab, nf != 15);
			$display("test read_backward %0d done", nf);
		end
		complete_run;
	end
endmodule

// ===== dv/processor_channel_model.sv
`timescale 1ns/1ps
module processor_channel_model (
	// bench control
	input  wire        i_clk,
	input  wire        i_rst_n,
	input  wire        i_go,
	input  wire [2:0]  i_code,
	input  wire        i_even,
	input  wire [3:0]  i_nwords,
	input  wire        i_stall,
	// device side
	input  wire        i_data_ready,
	output reg         o_func_valid,
	output reg  [2:0]  o_func_code,
	output reg         o_func_even_parity,
	output reg         o_data_valid,
	output reg  [29:0] o_data_word,
	output reg         o_data_last,
	output wire        o_word_ready
);
	reg [3:0] left, idx, nl, ni;
	reg       took;
	function [29:0] word_of(input [3:0] n);
		word_of = 30'h2b3c4d5e + 30'h01234567 * n;
	endfunction
	// handshake seen on the rising edge, acted on at the falling edge
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			took <= 1'b0;
		else
			took <= o_data_valid && i_data_ready;
	end
	assign o_word_ready = !i_stall;
	// function word, with the first of exactly the requested words driven in the same cycle
	always @(negedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{o_func_valid, o_func_code, o_func_even_parity} <= 5'h00;
			{o_data_valid, o_data_last, left, idx} <= 10'h000;
			o_data_word <= 30'h0;
		end else begin
			nl = i_go ? i_nwords : left - {3'h0, took};
			ni = i_go ? 4'h0 : idx + {3'h0, took};
			o_func_valid <= i_go;
			if (i_go) begin
				o_func_code <= i_code;
				o_func_even_parity <= i_even;
			end
			left <= nl;
			idx <= ni;
			o_data_valid <= nl != 4'h0;
			o_data_last <= nl == 4'h1;
			// released lines toggle every cycle between the last word's complement and the last word
			o_data_word <= (nl != 4'h0) ? word_of(ni) : ~o_data_word;
		end
	end
endmodule

// ===== dv/tape_fn_checker.sv
`timescale 1ns/1ps
`include "tape_fn_defines.vh"
module tape_fn_checker #(parameter ERASE_CYCLES = 8) (
	input wire               i_clk,
	input wire               i_rst_n,
	input wire               i_func_valid,
	input wire [`CODE_W-1:0] i_func_code,
	input wire               i_func_even_parity,
	input wire               i_track_count_selector,
	input wire               o_busy,
	input wire               i_data_valid,
	input wire               o_data_ready,
	input wire               o_word_valid,
	input wire [`WORD_W-1:0] o_word_data,
	input wire               i_word_ready,
	input wire               o_motion_fwd,
	input wire               o_erase_on,
	input wire               o_status_valid,
	input wire               o_ext_interrupt
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	reg [23:0] er_n;
	reg        er_only;
	wire take = !o_busy && i_func_valid && i_track_count_selector
		&& (i_func_code == `CODE_SKIP || i_func_code == `CODE_READ_BACK);
	// erase length count and erase-only mode latch
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			er_n <= 24'h0;
			er_only <= 1'b0;
		end else begin
			er_n <= o_erase_on ? er_n + 24'h1 : 24'h0;
			if (take)
				er_only <= i_func_code == `CODE_SKIP && i_func_even_parity;
		end
	end
	sequence s_take; take && !$past(o_busy); endsequence
	sequence s_word_in; i_data_valid && o_data_ready; endsequence
	property p_busy; s_take |=> o_busy; endproperty
	a_busy: assert property (p_busy) else $error("function not taken");
	property p_seven; !o_busy && i_func_valid && !i_track_count_selector |=> !o_busy; endproperty
	a_seven: assert property (p_seven) else $error("seven-track taken");
	property p_irq; (o_status_valid || o_ext_interrupt) |->
		(o_status_valid && o_ext_interrupt) ##1 !o_status_valid; endproperty
	a_irq: assert property (p_irq) else $error("status or interrupt pulse bad");
	property p_motion; $rose(o_motion_fwd) |-> $past(i_data_valid && o_data_ready); endproperty
	a_motion: assert property (p_motion) else $error("motion without word");
	property p_erase_start; $rose(o_erase_on) |-> o_motion_fwd && $past(o_motion_fwd, 3); endproperty
	a_erase_start: assert property (p_erase_start) else $error("erase before speed");
	property p_erase_len; $fell(o_erase_on) |-> er_n == ERASE_CYCLES; endproperty
	a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
	property p_erase_end; $fell(o_erase_on) && er_only |-> o_status_valid && !o_motion_fwd; endproperty
	a_erase_end: assert property (p_erase_end) else $error("no status after erase");
	property p_no_word; o_erase_on |-> !o_data_ready; endproperty
	a_no_word: assert property (p_no_word) else $error("word taken in erase");
	property p_word_hold; o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word_data);
	endproperty
	a_word_hold: assert property (p_word_hold) else $error("word dropped");
	c_word: cover property (s_word_in);
endmodule
bind nine_track_backward_read_and_erase tape_fn_checker #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (.*);

// ===== src/nine_track_backward_read_and_erase.v
`timescale 1ns/1ps
`include "tape_fn_defines.vh"
// How it works
// R1: four 30-bit words map onto fifteen 8-bit frames, both directions.
// R2: data words are 30 bits wide, bit 29 most significant.
// R3: first frame met reading backward is frame one of assembly.
// R4: partial final backward word gets zeros at its most significant end.
// R5: processor leaves bits 8 to 5 zero in backward-read function words.
// R6: no bad-track correction during backward read.
// R7: short blocks read backward give an extra word, first word low-zero-padded.
// R8: last backward word holds zeros high, original first word's leading bits low.
// R9: skip-then-write writes exactly like the ordinary nine-track write.
// R10: processor sends erase-only as code 7, even parity, nine-track format.
// R11: even parity on code 7 selects erase-only over skip-then-write.
// R12: processor sends erase-only only to a standard control unit.
// R13: processor supplies exactly one data word after erase-only.
// R14: that word starts forward motion; erase three inches at normal speed.
// R15: then discard the word, report status, raise external interrupt.
// R16: erase-only behaves like seven-track skip-write with stop code.
// R17: processor should use erase-only when recovery needs over three inches.
// R18: no tape motion for erase-only until the data word arrives.
module nine_track_backward_read_and_erase #(
	parameter ERASE_TIME_US = `ERASE_TIME_US,
	parameter ERASE_CYCLES  = ERASE_TIME_US * `CLK_MHZ
) (
	// clock, reset, enable
	input  wire                 i_clk,
	input  wire                 i_rst_n,
	input  wire                 i_ce,
	// function word
	input  wire                 i_func_valid,
	input  wire [`CODE_W-1:0]   i_func_code,
	input  wire                 i_func_even_parity,
	input  wire                 i_track_count_selector,
	output reg                  o_busy,
	// data words from processor
	input  wire                 i_data_valid,
	input  wire [`WORD_W-1:0]   i_data_word,
	input  wire                 i_data_last,
	output reg                  o_data_ready,
	// data words to processor
	output reg                  o_word_valid,
	output reg  [`WORD_W-1:0]   o_word_data,
	input  wire                 i_word_ready,
	// frames read backward from tape
	input  wire                 i_rd_frame_valid,
	input  wire [`FRAME_W-1:0]  i_rd_frame,
	input  wire                 i_rd_block_end,
	output reg                  o_rd_frame_ready,
	// frames to write
	output reg                  o_wr_frame_valid,
	output reg  [`FRAME_W-1:0]  o_wr_frame,
	input  wire                 i_wr_frame_ready,
	// tape unit
	input  wire                 i_at_speed,
	output reg                  o_motion_fwd,
	output reg                  o_motion_rev,
	output reg                  o_erase_on,
	// status and interrupt
	output reg                  o_status_valid,
	output reg                  o_status_abnormal,
	output reg                  o_ext_interrupt
);
	localparam [6:0] S_IDLE    = 7'h01;
	localparam [6:0] S_WAIT    = 7'h02;
	localparam [6:0] S_SPEEDUP = 7'h04;
	localparam [6:0] S_ERASE   = 7'h08;
	localparam [6:0] S_WRITE   = 7'h10;
	localparam [6:0] S_READ    = 7'h20;
	localparam [6:0] S_DONE    = 7'h40;
	localparam [`TIMER_W-1:0] ERASE_LAST = ERASE_CYCLES - 1;

	reg  [6:0]           state,  next_state;
	reg                  op_erase, next_op_erase;
	reg  [`ACC_W-1:0]    acc,    next_acc;
	reg  [`POS_W-1:0]    pos,    next_pos;
	reg                  last_seen, next_last_seen;
	reg  [`TIMER_W-1:0]  timer,  next_timer;
	reg  [3:0]           grp,    next_grp;
	reg  [1:0]           fcnt,   next_fcnt;
	reg  [`WORD_W-1:0]   spare,  next_spare;
	reg  [`WORD_W-1:0]   next_word_data;
	reg                  next_wr_valid;
	reg  [`FRAME_W-1:0]  next_wr_frame;
	reg                  next_abnormal;
	reg                  push;
	reg  [`WORD_W-1:0]   push_word;
	reg  [`ACC_W-1:0]    wide;
	reg                  sync1, sync2, sync3, at_speed;
	wire pop       = o_word_valid & i_word_ready;
	wire data_take = i_data_valid & o_data_ready;
	wire frm_take  = i_rd_frame_valid & o_rd_frame_ready;
	wire end_take  = i_rd_block_end & o_rd_frame_ready;
	wire wr_free   = ~o_wr_frame_valid | i_wr_frame_ready;

	// at-speed pin: three flops, level taken once the last two agree
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1    <= 1'b0;
			sync2    <= 1'b0;
			sync3    <= 1'b0;
			at_speed <= 1'b0;
		end else if (i_ce) begin
			sync1 <= i_at_speed;
			sync2 <= sync1;
			sync3 <= sync2;
			if (sync2 == sync3) begin
				at_speed <= sync3;
			end
		end
	end

	// sequencing, word assembly and frame packing
	always @* begin
		next_state     = state;
		next_op_erase  = op_erase;
		next_acc       = acc;
		next_pos       = pos;
		next_last_seen = last_seen;
		next_timer     = timer;
		next_grp       = grp;
		next_abnormal  = o_status_abnormal;
		next_wr_valid  = o_wr_frame_valid & ~i_wr_frame_ready;
		next_wr_frame  = o_wr_frame;
		push           = 1'b0;
		push_word      = acc[`WORD_W-1:0];
		wide           = acc | ({{(`ACC_W-`FRAME_W){1'b0}}, i_rd_frame} << pos);
		case (state)
			S_IDLE: begin
				if (i_func_valid && i_track_count_selector) begin
					// R11 parity split
					if (i_func_code == `CODE_SKIP) begin
						next_op_erase = i_func_even_parity;
						next_state    = S_WAIT;
					end else if (i_func_code == `CODE_READ_BACK) begin
						next_acc   = {`ACC_W{1'b0}};
						next_pos   = {`POS_W{1'b0}};
						next_grp   = 4'h0;
						next_state = S_READ;
					end
				end
			end
			S_WAIT: begin
				// R18 motion waits for word
				if (data_take) begin
					// R9 first word loads the packer, msb first
					next_acc       = {i_data_word, {`FRAME_W{1'b0}}};
					next_pos       = `WORD_BITS;
					next_last_seen = i_data_last;
					next_state     = S_SPEEDUP;
				end
			end
			S_SPEEDUP: begin
				// R14 erase timing starts at normal speed
				if (at_speed) begin
					next_timer = {`TIMER_W{1'b0}};
					next_state = S_ERASE;
				end
			end
			S_ERASE: begin
				next_timer = timer + 1'b1;
				if (timer == ERASE_LAST) begin
					// R15 erase-only drops the word here
					// R16 same path as skip, minus the write
					next_state = op_erase ? S_DONE : S_WRITE;
				end
			end
			S_WRITE: begin
				// R1 frames leave msb first, 15 per four words
				if (data_take) begin
					next_acc       = acc | ({i_data_word, {`FRAME_W{1'b0}}} >> pos);
					next_pos       = pos + `WORD_BITS;
					next_last_seen = i_data_last;
				end else if (wr_free) begin
					if (pos >= `FRAME_BITS || (last_seen && pos != 6'h00)) begin
						// R9 a short tail is zero-padded low
						next_wr_valid = 1'b1;
						next_wr_frame = acc[`ACC_W-1:`ACC_W-`FRAME_W];
						next_acc      = acc << `FRAME_BITS;
						next_pos      = (pos >= `FRAME_BITS) ? pos - `FRAME_BITS : 6'h00;
					end else if (last_seen) begin
						next_state = S_DONE;
					end
				end
			end
			S_READ: begin
				// R6 frames used as read, no track repair
				if (frm_take) begin
					// R3 first frame read lands in the low bits
					// R7 so pad bits of a short block end up low
					next_grp = (grp == `GRP_LAST) ? 4'h0 : grp + 1'b1;
					// R2 word closes at 30 bits
					if (pos + `FRAME_BITS >= `WORD_BITS) begin
						push      = 1'b1;
						push_word = wide[`WORD_W-1:0];
						next_acc  = {{`WORD_W{1'b0}}, wide[`ACC_W-1:`WORD_W]};
						next_pos  = pos + `FRAME_BITS - `WORD_BITS;
					end else begin
						next_acc = wide;
						next_pos = pos + `FRAME_BITS;
					end
				end else if (end_take) begin
					// R4 partial word keeps zeros at its top
					// R8 leading bits of first written word sit low
					push          = (pos != 6'h00);
					next_abnormal = (grp != 4'h0);
					next_state    = S_DONE;
				end
			end
			S_DONE: begin
				next_state = S_IDLE;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	// two-entry word buffer: head is the output register, spare behind it
	always @* begin
		next_fcnt      = fcnt;
		next_word_data = o_word_data;
		next_spare     = spare;
		if (push && !pop) begin
			next_fcnt = fcnt + 1'b1;
			if (fcnt == 2'h0) begin
				next_word_data = push_word;
			end else begin
				next_spare = push_word;
			end
		end else if (pop && !push) begin
			next_fcnt      = fcnt - 1'b1;
			next_word_data = spare;
		end else if (pop && push) begin
			if (fcnt == 2'h1) begin
				next_word_data = push_word;
			end else begin
				next_word_data = spare;
				next_spare     = push_word;
			end
		end
	end

	// state register; every output is a flop
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state             <= S_IDLE;
			op_erase          <= 1'b0;
			acc               <= {`ACC_W{1'b0}};
			pos               <= {`POS_W{1'b0}};
			last_seen         <= 1'b0;
			timer             <= {`TIMER_W{1'b0}};
			grp               <= 4'h0;
			fcnt              <= 2'h0;
			spare             <= {`WORD_W{1'b0}};
			o_word_data       <= {`WORD_W{1'b0}};
			o_word_valid      <= 1'b0;
			o_wr_frame_valid  <= 1'b0;
			o_wr_frame        <= {`FRAME_W{1'b0}};
			o_data_ready      <= 1'b0;
			o_rd_frame_ready  <= 1'b0;
			o_busy            <= 1'b0;
			o_motion_fwd      <= 1'b0;
			o_motion_rev      <= 1'b0;
			o_erase_on        <= 1'b0;
			o_status_valid    <= 1'b0;
			o_status_abnormal <= 1'b0;
			o_ext_interrupt   <= 1'b0;
		end else if (i_ce) begin
			state             <= next_state;
			op_erase          <= next_op_erase;
			acc               <= next_acc;
			pos               <= next_pos;
			last_seen         <= next_last_seen;
			timer             <= next_timer;
			grp               <= next_grp;
			fcnt              <= next_fcnt;
			spare             <= next_spare;
			o_word_data       <= next_word_data;
			o_word_valid      <= (next_fcnt != 2'h0);
			o_wr_frame_valid  <= next_wr_valid;
			o_wr_frame        <= next_wr_frame;
			o_status_abnormal <= (state == S_IDLE) ? 1'b0 : next_abnormal;
			// take a word only while the packer has room below one frame
			o_data_ready      <= (next_state == S_WAIT) ||
				(next_state == S_WRITE && next_pos < `FRAME_BITS && !next_last_seen);
			// stall the tape side while the word buffer is full
			o_rd_frame_ready  <= (next_state == S_READ) && (next_fcnt != `BUF_FULL);
			o_busy            <= (next_state != S_IDLE);
			// R14 forward motion from word arrival to completion
			o_motion_fwd      <= next_state[2] | next_state[3] | next_state[4];
			o_motion_rev      <= (next_state == S_READ);
			o_erase_on        <= (next_state == S_ERASE);
			// R15 status and interrupt at completion
			o_status_valid    <= (next_state == S_DONE);
			o_ext_interrupt   <= (next_state == S_DONE);
		end
	end
endmodule

// ===== src/tape_fn_defines.vh
`ifndef TAPE_FN_DEFINES_VH
`define TAPE_FN_DEFINES_VH

// word and frame geometry
`define WORD_W          30
`define FRAME_W         8
`define ACC_W           38
`define POS_W           6
`define WORD_BITS       6'h1e
`define FRAME_BITS      6'h08
`define FRAMES_PER_GRP  4'hf
`define GRP_LAST        4'he

// main function codes
`define CODE_W          3
`define CODE_SKIP       3'h7
`define CODE_READ_BACK  3'h3

// erase timing
`define CLK_MHZ         10
`define ERASE_TIME_US   30000
`define TIMER_W         24

// delivered word buffer
`define BUF_FULL        2'h2

`endif
